// [logic/xfer_clock_defs.svh]
// Purpose: Register offsets, field positions, reset values and counts for the transfer clock generator.
// Assumes: Included by the package and the design module.
// Notes: Definitions only.
`ifndef XFER_CLOCK_DEFS_SVH
`define XFER_CLOCK_DEFS_SVH
// ==========================================
// Register map
`define ADDR_W 4
`define DATA_W 16
`define OFS_DIVISOR 4'h0
`define OFS_CTRL_B 4'h4
`define OFS_CTRL_C 4'h8
`define OFS_STATUS 4'hC
`define RST_DIVISOR 16'h0040
`define RST_CTRL_B 16'h0000
`define RST_CTRL_C 16'h0060
// ==========================================
// Divisor fields
`define DIV_INT_HI 15
`define DIV_INT_LO 6
`define DIV_FRAC_HI 5
`define DIV_INT_W 10
`define DIV_FRAC_W 6
// ==========================================
// Control B fields
`define CB_DOUBLE 0
`define CB_OPEN_DRAIN 1
`define CB_INVERT 2
`define CB_SLAVE 3
// ==========================================
// Control C fields
`define CC_MODE_HI 1
`define CC_MODE_LO 0
`define CC_PAR_HI 3
`define CC_PAR_LO 2
`define CC_TWO_STOP 4
`define CC_SIZE_HI 7
`define CC_SIZE_LO 5
`define CC_LSB_FIRST 8
`define CC_PHASE 9
// ==========================================
// Encodings and counts
`define MODE_ASYNC 2'h0
`define MODE_SYNC 2'h1
`define MODE_SPI 2'h3
`define PAR_EVEN 2'h2
`define PAR_ODD 2'h3
`define SAMPLES_NORMAL 4'hF
`define SAMPLES_DOUBLE 4'h7
`define VOTE_NORMAL_FIRST 4'h8
`define VOTE_DOUBLE_FIRST 4'h4
`define MIN_DATA_BITS 4'h5
`define MAX_SIZE_CODE 3'h4
`define SPI_FRAME_BITS 4'h8
`define CLOCK_PERIOD_NS 20
`endif

// [logic/xfer_clock_pkg.sv]
// Purpose: Types shared by the transfer clock generator and its bench.
// Assumes: xfer_clock_defs.svh supplies all numbers.
// Notes: Nothing here is imported; users write xfer_clock_pkg::name.
`include "xfer_clock_defs.svh"
package xfer_clock_pkg;
  typedef enum logic [2:0] {CLK_ASYNC_NORMAL, CLK_ASYNC_DOUBLE, CLK_SYNC_MASTER, CLK_SYNC_SLAVE,
    CLK_SPI_MASTER} clock_mode_t;
  typedef struct packed {
    logic [3:0] data_bits;
    logic parity_on;
    logic parity_odd;
    logic two_stop;
    logic lsb_first;
    logic spi_frame;
  } frame_format_t;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : xfer_clock_pkg

// [logic/xfer_clock_gen.sv]
// Purpose: Bit-rate generator, transfer clock and frame-format logic of a serial transceiver.
// Assumes: One 50 MHz clock, synchronous inputs, software keeps settings still during a transfer.
// Notes: Shifters, buffers and error flags live elsewhere and use the ticks and format produced here.
`timescale 1ns/1ps
`include "xfer_clock_defs.svh"
module xfer_clock_gen #(
  parameter int DIV_INT_W = `DIV_INT_W
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire xfer_clock_pkg::reg_req_t i_reg,
  input wire logic i_xfer_active,
  input wire logic i_tx_active,
  input wire logic i_tx_bit,
  input wire logic [8:0] i_tx_data,
  input wire logic i_rxd,
  input wire logic i_xck_in,
  output logic [`DATA_W-1:0] o_rd_data,
  output logic o_sample_tick,
  output logic o_bit_tick,
  output logic o_change_pulse,
  output logic o_sample_pulse,
  output logic o_xck_out,
  output logic o_xck_oe,
  output logic o_txd_out,
  output logic o_txd_oe,
  output logic o_parity,
  output logic o_start_ok,
  output logic o_start_reject,
  output logic [1:0] o_spi_mode,
  output logic [3:0] o_frame_len,
  output xfer_clock_pkg::frame_format_t o_format
);
  // The divisor layout fixes the integer field, so any other width is refused at elaboration.
  if (DIV_INT_W != `DIV_INT_W) begin : g_bad_width
    $error("integer field width must match the divisor layout");
  end

  // ==========================================
  // Registers
  logic [`DATA_W-1:0] divisor, ctrl_b, ctrl_c, next_divisor, next_ctrl_b, next_ctrl_c, next_rd_data;
  xfer_clock_pkg::clock_mode_t mode;
  xfer_clock_pkg::frame_format_t fmt;
  logic [1:0] mode_sel;
  logic invert, phase, clk_level;
  logic [3:0] frame_len;

  always_comb begin
    next_divisor = divisor;
    next_ctrl_b = ctrl_b;
    next_ctrl_c = ctrl_c;
    next_rd_data = '0;
    if (i_reg.wr) begin
      unique case (i_reg.addr)
        `OFS_DIVISOR: next_divisor = i_reg.wdata;
        `OFS_CTRL_B: next_ctrl_b = i_reg.wdata;
        `OFS_CTRL_C: next_ctrl_c = i_reg.wdata;
        default: ;
      endcase
    end
    if (i_reg.rd) begin
      unique case (i_reg.addr)
        `OFS_DIVISOR: next_rd_data = divisor;
        `OFS_CTRL_B: next_rd_data = ctrl_b;
        `OFS_CTRL_C: next_rd_data = ctrl_c;
        `OFS_STATUS: next_rd_data = {8'h00, clk_level, 3'(mode), frame_len};
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      divisor <= `RST_DIVISOR;
      ctrl_b <= `RST_CTRL_B;
      ctrl_c <= `RST_CTRL_C;
      o_rd_data <= '0;
    end else begin
      divisor <= next_divisor;
      ctrl_b <= next_ctrl_b;
      ctrl_c <= next_ctrl_c;
      o_rd_data <= next_rd_data;
    end
  end

  // ==========================================
  // Mode and frame format decode
  logic [2:0] size_code;
  always_comb begin
    mode_sel = ctrl_c[`CC_MODE_HI:`CC_MODE_LO];
    invert = ctrl_b[`CB_INVERT];
    phase = ctrl_c[`CC_PHASE];
    if (mode_sel == `MODE_SPI) mode = xfer_clock_pkg::CLK_SPI_MASTER;
    else if (mode_sel == `MODE_SYNC && ctrl_b[`CB_SLAVE]) mode = xfer_clock_pkg::CLK_SYNC_SLAVE;
    else if (mode_sel == `MODE_SYNC) mode = xfer_clock_pkg::CLK_SYNC_MASTER;
    else if (ctrl_b[`CB_DOUBLE]) mode = xfer_clock_pkg::CLK_ASYNC_DOUBLE;
    else mode = xfer_clock_pkg::CLK_ASYNC_NORMAL;
    // Codes above nine bits clamp to nine so every setting is a legal frame.
    size_code = (ctrl_c[`CC_SIZE_HI:`CC_SIZE_LO] > `MAX_SIZE_CODE) ? `MAX_SIZE_CODE : ctrl_c[`CC_SIZE_HI:`CC_SIZE_LO];
    fmt.spi_frame = (mode == xfer_clock_pkg::CLK_SPI_MASTER);
    fmt.data_bits = fmt.spi_frame ? `SPI_FRAME_BITS : `MIN_DATA_BITS + 4'(size_code);
    fmt.parity_on = !fmt.spi_frame && ctrl_c[`CC_PAR_HI];
    fmt.parity_odd = ctrl_c[`CC_PAR_HI:`CC_PAR_LO] == `PAR_ODD;
    fmt.two_stop = !fmt.spi_frame && ctrl_c[`CC_TWO_STOP];
    fmt.lsb_first = ctrl_c[`CC_LSB_FIRST];
    frame_len = fmt.spi_frame ? fmt.data_bits : 4'(fmt.data_bits + 4'(fmt.parity_on) + 4'(fmt.two_stop) + 4'h2);
  end

  // ==========================================
  // Rate generator and transfer clock
  logic [DIV_INT_W-1:0] int_part, cnt, next_cnt;
  logic [`DIV_FRAC_W-1:0] acc, next_acc;
  logic stretch, next_stretch, tick, next_clk_level, is_async, is_master;
  logic [3:0] scnt, next_scnt, last_sample;
  logic [DIV_INT_W:0] limit;
  logic xck_s1, xck_s2;

  always_comb begin
    int_part = (divisor[`DIV_INT_HI:`DIV_INT_LO] == '0) ? DIV_INT_W'(1) : divisor[`DIV_INT_HI:`DIV_INT_LO];
    is_async = mode == xfer_clock_pkg::CLK_ASYNC_NORMAL || mode == xfer_clock_pkg::CLK_ASYNC_DOUBLE;
    is_master = mode == xfer_clock_pkg::CLK_SYNC_MASTER || mode == xfer_clock_pkg::CLK_SPI_MASTER;
    last_sample = (mode == xfer_clock_pkg::CLK_ASYNC_DOUBLE) ? `SAMPLES_DOUBLE : `SAMPLES_NORMAL;
    // In async mode the period is int + frac/64 clocks, so rate = 64*f/(S*divisor).
    limit = {1'b0, int_part} + (DIV_INT_W+1)'(stretch);
    tick = 1'b0;
    next_cnt = cnt + DIV_INT_W'(1);
    next_acc = acc;
    next_stretch = stretch;
    next_scnt = scnt;
    next_clk_level = clk_level;
    if (is_async) begin
      next_clk_level = 1'b0;
      if ({1'b0, cnt} >= limit - (DIV_INT_W+1)'(1)) begin
        tick = 1'b1;
        next_cnt = '0;
        {next_stretch, next_acc} = {1'b0, acc} + {1'b0, divisor[`DIV_FRAC_HI:0]};
        next_scnt = (scnt == last_sample) ? 4'h0 : scnt + 4'h1;
      end
    end else if (is_master) begin
      next_scnt = '0;
      next_acc = '0;
      next_stretch = 1'b0;
      if (!i_xfer_active) begin
        next_cnt = '0;
        next_clk_level = 1'b0;
      end else if (cnt >= int_part - DIV_INT_W'(1)) begin
        next_cnt = '0;
        next_clk_level = !clk_level;
      end
    end else begin
      next_cnt = '0;
      next_scnt = '0;
      next_acc = '0;
      next_stretch = 1'b0;
      next_clk_level = xck_s2 ^ invert;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cnt <= '0;
      acc <= '0;
      stretch <= 1'b0;
      scnt <= '0;
      clk_level <= 1'b0;
      xck_s1 <= 1'b1;
      xck_s2 <= 1'b1;
    end else begin
      cnt <= next_cnt;
      acc <= next_acc;
      stretch <= next_stretch;
      scnt <= next_scnt;
      clk_level <= next_clk_level;
      xck_s1 <= i_xck_in;
      xck_s2 <= xck_s1;
    end
  end

  // ==========================================
  // Start bit vote
  typedef enum logic [1:0] {HUNT, COUNT, VOTE} vote_state_t;
  vote_state_t vstate, next_vstate;
  logic [3:0] vcnt, next_vcnt, vote_first;
  logic [1:0] lows, next_lows;
  logic rx_prev, next_rx_prev, next_start_ok, next_start_reject, do_sample;

  always_comb begin
    vote_first = (mode == xfer_clock_pkg::CLK_ASYNC_DOUBLE) ? `VOTE_DOUBLE_FIRST : `VOTE_NORMAL_FIRST;
    do_sample = tick && is_async;
    next_vstate = vstate;
    next_vcnt = vcnt;
    next_lows = lows;
    next_rx_prev = do_sample ? i_rxd : rx_prev;
    next_start_ok = 1'b0;
    next_start_reject = 1'b0;
    if (!is_async) begin
      next_vstate = HUNT;
      next_rx_prev = 1'b1;
    end else if (do_sample) begin
      unique case (vstate)
        HUNT: begin
          next_vcnt = 4'h1;
          next_lows = '0;
          if (rx_prev && !i_rxd) next_vstate = COUNT;
        end
        COUNT: begin
          next_vcnt = vcnt + 4'h1;
          if (vcnt + 4'h1 == vote_first) begin
            next_vstate = VOTE;
            next_lows = 2'(!i_rxd);
          end
        end
        VOTE: begin
          next_vcnt = vcnt + 4'h1;
          if (vcnt + 4'h1 == vote_first + 4'h2) begin
            next_vstate = HUNT;
            // Two lows of three accept; otherwise a noise spike is dropped.
            next_start_ok = (lows + 2'(!i_rxd)) >= 2'h2;
            next_start_reject = !next_start_ok;
          end else begin
            next_lows = lows + 2'(!i_rxd);
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      vstate <= HUNT;
      vcnt <= '0;
      lows <= '0;
      rx_prev <= 1'b1;
      o_start_ok <= 1'b0;
      o_start_reject <= 1'b0;
    end else begin
      vstate <= next_vstate;
      vcnt <= next_vcnt;
      lows <= next_lows;
      rx_prev <= next_rx_prev;
      o_start_ok <= next_start_ok;
      o_start_reject <= next_start_reject;
    end
  end

  // ==========================================
  // Pins, edges and parity
  logic rise, fall, next_change, next_samp, next_txd_val, next_par;
  logic [8:0] data_mask;

  always_comb begin
    rise = next_clk_level && !clk_level;
    fall = !next_clk_level && clk_level;
    // Internal level is pin xor inversion, so change is its rise and sample its fall, except in SPI with the phase bit clear, where they swap.
    if (mode == xfer_clock_pkg::CLK_SPI_MASTER) begin
      next_change = phase ? rise : fall;
      next_samp = phase ? fall : rise;
    end else begin
      next_change = !is_async && rise;
      next_samp = !is_async && fall;
    end
    next_txd_val = i_tx_active ? i_tx_bit : 1'b1;
    data_mask = 9'h1FF >> (4'h9 - fmt.data_bits);
    next_par = (^(i_tx_data & data_mask)) ^ fmt.parity_odd;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_sample_tick <= 1'b0;
      o_bit_tick <= 1'b0;
      o_change_pulse <= 1'b0;
      o_sample_pulse <= 1'b0;
      o_xck_out <= 1'b0;
      o_xck_oe <= 1'b0;
      o_txd_out <= 1'b1;
      o_txd_oe <= 1'b0;
      o_parity <= 1'b0;
      o_spi_mode <= '0;
      o_frame_len <= '0;
      o_format <= '0;
    end else begin
      o_sample_tick <= tick && is_async;
      o_bit_tick <= tick && is_async && scnt == last_sample;
      o_change_pulse <= next_change;
      o_sample_pulse <= next_samp;
      o_xck_out <= next_clk_level ^ invert;
      o_xck_oe <= is_master;
      o_txd_out <= ctrl_b[`CB_OPEN_DRAIN] ? 1'b0 : next_txd_val;
      o_txd_oe <= ctrl_b[`CB_OPEN_DRAIN] ? !next_txd_val : i_tx_active;
      o_parity <= next_par;
      o_spi_mode <= {invert, phase};
      o_frame_len <= frame_len;
      o_format <= fmt;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic [DIV_INT_W+1:0] gap;
  logic cfg_quiet;
  always_ff @(posedge i_clock) begin
    if (i_srst || o_sample_tick) gap <= '0;
    else gap <= gap + (DIV_INT_W+2)'(1);
    if (i_srst || i_reg.wr || !is_async) cfg_quiet <= 1'b0;
    else if (o_sample_tick) cfg_quiet <= 1'b1;
  end
  sequence rx_fall_s;
    do_sample && vstate == HUNT && rx_prev && !i_rxd;
  endsequence
  tick_gap_a: assert property (o_sample_tick && cfg_quiet && $past(cfg_quiet) |->
    gap + 1 >= int_part && gap + 1 <= int_part + 1) else $error("sample period off");
  bit_tick_a: assert property (o_bit_tick |-> o_sample_tick) else $error("bit tick without sample");
  xck_dir_a: assert property (!i_srst |=> o_xck_oe == $past(is_master)) else $error("clock pin direction");
  edge_apart_a: assert property (!(o_change_pulse && o_sample_pulse)) else $error("change and sample together");
  spi_number_a: assert property (!i_srst |=> o_spi_mode == $past({invert, phase}))
    else $error("spi mode number");
  parity_val_a: assert property (!i_srst |=> o_parity == $past(next_par)) else $error("parity bit wrong");
  idle_high_a: assert property (!i_tx_active && !ctrl_b[`CB_OPEN_DRAIN] && !i_reg.wr |=> o_txd_out)
    else $error("line not idle high");
  wired_and_a: assert property (o_txd_oe && $past(ctrl_b[`CB_OPEN_DRAIN]) |-> !o_txd_out)
    else $error("open drain drove high");
  spi_len_a: assert property (fmt.spi_frame |=> o_frame_len == `SPI_FRAME_BITS || $past(i_reg.wr))
    else $error("spi frame length");
  vote_end_a: assert property (rx_fall_s ##1 (vstate == COUNT && is_async) [*1] |-> ##[1:300]
    (o_start_ok || o_start_reject || !is_async || i_reg.wr)) else $error("start vote never ended");
endmodule : xfer_clock_gen

// [test/serial_peer.sv]
// Purpose: Far-side serial peer that drives the receive line and a slave transfer clock.
// Assumes: Runs on the bench clock; commands arrive by non-blocking assignment.
// Notes: The transfer clock stands still low outside runs.
`timescale 1ns/1ps
module serial_peer (
  input wire logic i_clock,
  input wire logic i_run_clk,
  input wire logic i_send_low,
  input wire logic [7:0] i_low_len,
  output logic o_rxd,
  output logic o_xck
);
  logic [7:0] low_cnt = 8'h00;
  logic [1:0] div_cnt = 2'h0;
  initial o_xck = 1'b0;
  // ==========================================
  // Receive line and transfer clock
  assign o_rxd = (low_cnt == 8'h00);
  always @(posedge i_clock) begin
    if (i_send_low) begin
      low_cnt <= i_low_len;
    end else if (low_cnt != 8'h00) begin
      low_cnt <= low_cnt - 8'h01;
    end
    // Four clocks a phase keeps the rate at one eighth, so every phase is seen twice or more.
    div_cnt <= i_run_clk ? div_cnt + 2'h1 : 2'h0;
    if (!i_run_clk) begin
      o_xck <= 1'b0;
    end else if (div_cnt == 2'h3) begin
      o_xck <= ~o_xck;
    end
  end
endmodule : serial_peer

// [test/serial_clock_gen_frame_format_tb_top.sv]
// Purpose: Self-checking bench for the transfer clock generator.
// Assumes: 50 MHz clock, reset held four cycles.
// Notes: Every wait is bounded; a spent bound ends the run.
`timescale 1ns/1ps
`include "xfer_clock_defs.svh"
module serial_clock_gen_frame_format_tb_top;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  xfer_clock_pkg::reg_req_t reg_req = '0;
  logic xfer_active = 1'b0;
  logic tx_active = 1'b0;
  logic tx_bit = 1'b0;
  logic [8:0] tx_data = 9'h1B5;
  logic run_clk = 1'b0;
  logic send_low = 1'b0;
  logic [7:0] low_len = 8'h00;
  logic rxd, transfer_clock_pin, sample_tick, bit_tick, change_pulse, sample_pulse, xck_out, xck_oe;
  logic txd_out, txd_oe, parity, start_ok, start_reject;
  logic [15:0] rd_data;
  logic [15:0] rv;
  logic [1:0] spi_mode;
  logic [3:0] frame_len;
  xfer_clock_pkg::frame_format_t fmt;
  int error_cnt = 0;
  int compares = 0;
  int n;
  int sum;
  always #(`CLOCK_PERIOD_NS / 2) i_clock = ~i_clock;
  xfer_clock_gen u_xfer_clock_gen (.i_clock(i_clock), .i_srst(i_srst), .i_reg(reg_req),
    .i_xfer_active(xfer_active), .i_tx_active(tx_active), .i_tx_bit(tx_bit), .i_tx_data(tx_data),
    .i_rxd(rxd), .i_xck_in(transfer_clock_pin), .o_rd_data(rd_data), .o_sample_tick(sample_tick), .o_bit_tick(bit_tick),
    .o_change_pulse(change_pulse), .o_sample_pulse(sample_pulse), .o_xck_out(xck_out), .o_xck_oe(xck_oe),
    .o_txd_out(txd_out), .o_txd_oe(txd_oe), .o_parity(parity), .o_start_ok(start_ok),
    .o_start_reject(start_reject), .o_spi_mode(spi_mode), .o_frame_len(frame_len), .o_format(fmt));
  serial_peer u_serial_peer (.i_clock(i_clock), .i_run_clk(run_clk), .i_send_low(send_low),
    .i_low_len(low_len), .o_rxd(rxd), .o_xck(transfer_clock_pin));
  // ==========================================
  // Shared tasks
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk
  // Writes wait two more edges so the registered outputs already show the new setting.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clock);
    reg_req.wr <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clock);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clock);
    reg_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd
  function automatic logic pick(input int sel);
    case (sel)
      0: return sample_tick;
      1: return bit_tick;
      2: return change_pulse;
      3: return sample_pulse;
      4: return start_ok;
      default: return start_reject;
    endcase
  endfunction : pick
  task automatic wait_pulse(input int sel, output int cyc);
    for (cyc = 1; cyc <= 500; cyc++) begin
      @(posedge i_clock);
      #1;
      if (pick(sel) === 1'b1) return;
    end
    $display("CHECK FAILED pulse %0d expected 1 seen 0", sel);
    error_cnt++;
    summarize();
  endtask : wait_pulse
  // ==========================================
  // Scenarios
  task automatic t_regs();
    chk("txd idle", 16'h0001, {15'h0, txd_out});
    rd(`OFS_DIVISOR, rv);
    chk("divisor", `RST_DIVISOR, rv);
    rd(`OFS_CTRL_C, rv);
    chk("ctrl c", `RST_CTRL_C, rv);
    rd(`OFS_CTRL_B, rv);
    chk("ctrl b", `RST_CTRL_B, rv);
    wr(4'h2, 16'hFFFF);
    rd(4'h2, rv);
    chk("unmapped", 16'h0000, rv);
    wr(`OFS_DIVISOR, 16'hABCD);
    rd(`OFS_DIVISOR, rv);
    chk("divisor rw", 16'hABCD, rv);
  endtask : t_regs
  task automatic t_async();
    wr(`OFS_DIVISOR, 16'h0100);
    wait_pulse(0, n);
    wait_pulse(0, n);
    chk("sample gap", 16'h0004, 16'(n));
    wait_pulse(1, n);
    wait_pulse(1, n);
    chk("bit normal", 16'h0040, 16'(n));
    wr(`OFS_CTRL_B, 16'h0001);
    wait_pulse(1, n);
    wait_pulse(1, n);
    chk("bit double", 16'h0020, 16'(n));
    rd(`OFS_STATUS, rv);
    chk("mode code", 16'h0001, {13'h0, rv[6:4]});
    wr(`OFS_CTRL_B, 16'h0000);
    wr(`OFS_DIVISOR, 16'h0120);
    wait_pulse(0, n);
    sum = 0;
    repeat (32) begin
      wait_pulse(0, n);
      sum += n;
    end
    chk("fraction", 16'h0090, 16'(sum));
  endtask : t_async
  task automatic t_master();
    wr(`OFS_DIVISOR, 16'h00C0);
    for (int i = 0; i < 8; i++) begin
      // Phase and inversion change only while no transfer runs.
      xfer_active <= 1'b0;
      wr(`OFS_CTRL_B, {13'h0, i[1], 2'h0});
      wr(`OFS_CTRL_C, {6'h0, i[0], 7'h0, i[2] ? `MODE_SPI : `MODE_SYNC});
      xfer_active <= 1'b1;
      rd(`OFS_STATUS, rv);
      chk("mode code", i[2] ? 16'h0004 : 16'h0002, {13'h0, rv[6:4]});
      chk("spi mode", {14'h0, i[1], i[0]}, {14'h0, spi_mode});
      chk("xck oe", 16'h0001, {15'h0, xck_oe});
      wait_pulse(2, n);
      wait_pulse(2, n);
      chk("sync rate", 16'h0006, 16'(n));
      wait_pulse(3, n);
      chk("sample edge", {15'h0, (i[2] & ~i[0]) ^ i[1]}, {15'h0, xck_out});
    end
    xfer_active <= 1'b0;
  endtask : t_master
  task automatic t_slave();
    wr(`OFS_CTRL_B, 16'h0008);
    wr(`OFS_CTRL_C, 16'h0061);
    run_clk <= 1'b1;
    wait_pulse(2, n);
    wait_pulse(2, n);
    chk("slave gap", 16'h0008, 16'(n));
    chk("xck oe", 16'h0000, {15'h0, xck_oe});
    rd(`OFS_STATUS, rv);
    chk("mode code", 16'h0003, {13'h0, rv[6:4]});
    run_clk <= 1'b0;
  endtask : t_slave
  task automatic t_frame();
    for (int sz = 0; sz < 5; sz++) begin
      for (int p = 1; p < 4; p++) begin
        for (int st = 0; st < 2; st++) begin
          wr(`OFS_CTRL_C, 16'((sz << 5) | (p << 2) | (st << 4)));
          chk("frame len", 16'(7 + sz + p[1] + st), {12'h0, frame_len});
          if (p[1]) begin
            chk("parity", {15'h0, ^(tx_data & 9'((1 << (5 + sz)) - 1)) ^ p[0]}, {15'h0, parity});
          end
        end
      end
    end
    wr(`OFS_CTRL_C, 16'h0163);
    chk("spi len", 16'h0008, {12'h0, frame_len});
    chk("spi fmt", 16'h0003, {13'h0, fmt.parity_on, fmt.lsb_first, fmt.spi_frame});
  endtask : t_frame
  task automatic t_vote();
    wr(`OFS_CTRL_C, 16'h0060);
    wr(`OFS_DIVISOR, 16'h0080);
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_CTRL_B, {15'h0, k[1]});
      low_len <= k[0] ? 8'h28 : 8'h04;
      send_low <= 1'b1;
      @(posedge i_clock);
      send_low <= 1'b0;
      wait_pulse(k[0] ? 4 : 5, n);
      chk("vote other", 16'h0000, {15'h0, k[0] ? start_reject : start_ok});
      repeat (80) @(posedge i_clock);
    end
  endtask : t_vote
  task automatic t_txd();
    logic v;
    for (int k = 0; k < 8; k++) begin
      wr(`OFS_CTRL_B, {14'h0, k[2], 1'b0});
      tx_active <= k[1];
      tx_bit <= k[0];
      repeat (2) @(posedge i_clock);
      #1;
      v = k[1] ? k[0] : 1'b1;
      chk("txd pin", k[2] ? {15'h0, ~v} : {14'h0, v, k[1]}, {14'h0, txd_out, txd_oe});
    end
  endtask : t_txd
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    #1;
    // The line idles high from reset and rate and format are set before any transfer starts.
    t_regs();
    // The block raises no interrupt, so set-up never races one.
    t_async();
    t_master();
    t_slave();
    t_frame();
    t_vote();
    t_txd();
    summarize();
  end
endmodule : serial_clock_gen_frame_format_tb_top
